// [core/debug_ctrl_regs.svh]
// Constants for the debug status, control and breakpoint block
`ifndef DEBUG_CTRL_REGS_SVH
`define DEBUG_CTRL_REGS_SVH

// ----------------------------------------------------------------
// Status and control byte field positions
// ----------------------------------------------------------------
`define HALT_PERMIT_BIT 7
`define HALT_ACTIVE_BIT 6
`define BKPT_ENABLE_BIT 5
`define FORCE_TAG_BIT 4
`define COMM_CLOCK_BIT 3
`define WAIT_STOP_BIT 2
`define WAIT_STOP_FAIL_BIT 1
`define DATA_VALID_FAIL_BIT 0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define STATUS_CONTROL_RESET 8'h00
`define STATUS_CONTROL_HALT_RESET 8'hC8
`define BKPT_ADDR_RESET 16'h0000
`define FORCE_RESET_READ 8'h00

// ----------------------------------------------------------------
// Memory-map location of the force-reset register
// ----------------------------------------------------------------
`define FORCE_RESET_ADDR 16'h1800
`define FORCE_TARGET_RESET_BIT 0

`endif

// [core/debug_ctrl_pkg.sv]
// Types shared by the debug control block
package debug_ctrl_pkg;

    // Progress of a request to enter debug halt mode
    typedef enum logic [2:0]
    {
        HALT_RUN = 3'h1,
        HALT_REQ = 3'h2,
        HALT_HELD = 3'h4
    } halt_state_type;

endpackage : debug_ctrl_pkg

// [core/pin_sync.sv]
// Three-stage synchroniser with agreement filter for one input
`timescale 1ns/1ps
module pin_sync
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic async_in,
    output logic sync_out
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic agree;

    // Stage two and three must agree before the output follows
    assign agree = (s2_reg == s3_reg);

    // Capture chain and filtered output
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            sync_out <= 1'b0;
        end
        else if (ce)
        begin
            s1_reg <= async_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (agree)
                sync_out <= s3_reg;
        end
    end
endmodule : pin_sync

// [core/bkpt_compare.sv]
// Address breakpoint comparator for forced and tagged hits
`timescale 1ns/1ps
module bkpt_compare
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic bkpt_enable,
    input wire logic force_tag_select,
    input wire logic [15:0] match_addr,
    input wire logic [15:0] cpu_addr,
    input wire logic cpu_addr_valid,
    input wire logic cpu_opcode_fetch,
    output logic force_hit,
    output logic tag_hit
);
    logic addr_hit;

    // Match only with the breakpoint enabled
    assign addr_hit = bkpt_enable && cpu_addr_valid && (cpu_addr == match_addr);

    // Registered hit pulses, one cycle after the bus cycle
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            force_hit <= 1'b0;
            tag_hit <= 1'b0;
        end
        else if (ce)
        begin
            force_hit <= addr_hit && force_tag_select;
            tag_hit <= addr_hit && !force_tag_select && cpu_opcode_fetch;
        end
    end
endmodule : bkpt_compare

// [core/debug_ctrl_status_breakpoint.sv]
// Status, control, breakpoint and force-reset registers of the debug controller
`timescale 1ns/1ps
`include "debug_ctrl_regs.svh"

module debug_ctrl_status_breakpoint
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic reset_in_halt,
    input wire logic status_read,
    input wire logic control_write,
    input wire logic [7:0] control_wdata,
    output logic [7:0] status_rdata,
    input wire logic breakpoint_store_cmd,
    input wire logic breakpoint_fetch_cmd,
    input wire logic [15:0] bkpt_wdata,
    output logic [15:0] bkpt_rdata,
    input wire logic halt_cmd,
    input wire logic mem_wr,
    input wire logic mem_rd,
    input wire logic mem_from_debug,
    input wire logic [15:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] mem_rdata,
    output logic mem_hit,
    input wire logic mem_fail_wait_stop,
    input wire logic cpu_wait_stop,
    input wire logic cpu_halted,
    input wire logic [15:0] cpu_addr,
    input wire logic cpu_addr_valid,
    input wire logic cpu_opcode_fetch,
    input wire logic cpu_inst_boundary,
    output logic halt_request,
    output logic wake_request,
    output logic opcode_tag,
    output logic comm_clock_select,
    output logic target_reset
);
    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    debug_ctrl_pkg::halt_state_type state_reg;
    debug_ctrl_pkg::halt_state_type state_next;
    logic halt_permit_reg;
    logic halt_permit_next;
    logic breakpoint_enable_reg;
    logic force_tag_select_reg;
    logic comm_clock_select_reg;
    logic halt_from_ws_reg;
    logic wait_stop_failure_reg;
    logic force_pending_reg;
    logic halted_q_reg;
    logic [15:0] breakpoint_match_address_reg;
    logic reset_pulse_reg;
    logic wait_stop_sync;
    logic force_hit;
    logic tag_hit;
    logic halt_active;
    logic wait_stop_status;
    logic data_valid_failure;
    logic halt_leave;
    logic permit_writable;
    logic force_at_boundary;
    logic halt_wanted;
    logic force_reg_sel;
    logic force_reset_write;
    logic [7:0] status_byte;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------

    // Address decode of the force-reset register, used on reads and writes
    function automatic logic is_force_reset(input logic [15:0] addr);
        is_force_reset = (addr == `FORCE_RESET_ADDR);
    endfunction : is_force_reset

    // ----------------------------------------------------------------
    // Input conditioning
    // ----------------------------------------------------------------

    // Wait/stop comes from the low-power domain whose clock may stop
    pin_sync u_ws_sync
    (
        .mclk(mclk),
        .rst_n(rst_n),
        .ce(ce),
        .async_in(cpu_wait_stop),
        .sync_out(wait_stop_sync)
    );

    // Breakpoint comparison on the CPU address bus
    bkpt_compare u_bkpt
    (
        .mclk(mclk),
        .rst_n(rst_n),
        .ce(ce),
        .bkpt_enable(breakpoint_enable_reg),
        .force_tag_select(force_tag_select_reg),
        .match_addr(breakpoint_match_address_reg),
        .cpu_addr(cpu_addr),
        .cpu_addr_valid(cpu_addr_valid),
        .cpu_opcode_fetch(cpu_opcode_fetch),
        .force_hit(force_hit),
        .tag_hit(tag_hit)
    );

    // ----------------------------------------------------------------
    // Status decode
    // ----------------------------------------------------------------

    // Halt active follows the CPU's own halted state
    assign halt_active = cpu_halted;
    assign halt_leave = halted_q_reg && !cpu_halted;
    // Wait/stop, or halt entered from wait/stop
    assign wait_stop_status = wait_stop_sync || halt_from_ws_reg;
    // No slow memory in this part
    assign data_valid_failure = 1'b0;
    assign permit_writable = !cpu_halted;
    assign force_at_boundary = force_pending_reg && cpu_inst_boundary;
    // Any halt source is honoured only with permission
    assign halt_wanted = halt_permit_reg && (halt_cmd || force_at_boundary);

    // Assembled status and control byte
    assign status_byte = {halt_permit_reg, halt_active, breakpoint_enable_reg,
        force_tag_select_reg, comm_clock_select_reg, wait_stop_status,
        wait_stop_failure_reg, data_valid_failure};

    // Out of reset, halt permit only ever sets through a write, and not while halted
    assign halt_permit_next = halt_permit_reg
        || (control_write && permit_writable && control_wdata[`HALT_PERMIT_BIT]);

    // ----------------------------------------------------------------
    // Force-reset register decode
    // ----------------------------------------------------------------
    assign force_reg_sel = is_force_reset(mem_addr);
    // Only serial debug writes count; user writes fall away
    assign force_reset_write = mem_wr && mem_from_debug && force_reg_sel
        && mem_wdata[`FORCE_TARGET_RESET_BIT];
    assign mem_hit = (mem_wr || mem_rd) && force_reg_sel;

    // ----------------------------------------------------------------
    // Halt request state machine
    // ----------------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            debug_ctrl_pkg::HALT_RUN:
            begin
                if (cpu_halted)
                    state_next = debug_ctrl_pkg::HALT_HELD;
                else if (halt_wanted)
                    state_next = debug_ctrl_pkg::HALT_REQ;
            end
            debug_ctrl_pkg::HALT_REQ:
            begin
                if (cpu_halted)
                    state_next = debug_ctrl_pkg::HALT_HELD;
            end
            debug_ctrl_pkg::HALT_HELD:
            begin
                if (!cpu_halted)
                    state_next = debug_ctrl_pkg::HALT_RUN;
            end
            default:
                state_next = debug_ctrl_pkg::HALT_RUN;
        endcase
    end

    // Request held until the CPU reports halted; wake wait/stop as well
    assign halt_request = (state_reg == debug_ctrl_pkg::HALT_REQ);
    assign wake_request = halt_request && wait_stop_sync;
    // Tag only reaches the CPU when halting is permitted
    assign opcode_tag = tag_hit && halt_permit_reg;
    assign comm_clock_select = comm_clock_select_reg;
    assign target_reset = reset_pulse_reg;

    // ----------------------------------------------------------------
    // State and halt permit
    // ----------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            state_reg <= debug_ctrl_pkg::HALT_RUN;
            halted_q_reg <= 1'b0;
        end
        else if (ce)
        begin
            state_reg <= state_next;
            halted_q_reg <= cpu_halted;
        end
    end

    // Permit, clock select: reset value depends on reset into halt
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            halt_permit_reg <= reset_in_halt;
            comm_clock_select_reg <= reset_in_halt;
        end
        else if (ce)
        begin
            halt_permit_reg <= halt_permit_next;
            if (control_write)
                comm_clock_select_reg <= control_wdata[`COMM_CLOCK_BIT];
        end
    end

    // ----------------------------------------------------------------
    // Breakpoint control bits and address
    // ----------------------------------------------------------------

    // Control write touches only writable bits; status bits are derived
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            breakpoint_enable_reg <= 1'b0;
            force_tag_select_reg <= 1'b0;
        end
        else if (ce && control_write)
        begin
            breakpoint_enable_reg <= control_wdata[`BKPT_ENABLE_BIT];
            force_tag_select_reg <= control_wdata[`FORCE_TAG_BIT];
        end
    end

    // Address register reached only by the dedicated debug command
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            breakpoint_match_address_reg <= `BKPT_ADDR_RESET;
        else if (ce && breakpoint_store_cmd)
            breakpoint_match_address_reg <= bkpt_wdata;
    end

    // Forced hit waits for the next instruction boundary
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            force_pending_reg <= 1'b0;
        else if (ce)
        begin
            if (force_hit)
                force_pending_reg <= 1'b1;
            else if (cpu_inst_boundary || !breakpoint_enable_reg)
                force_pending_reg <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Sticky status flags
    // ----------------------------------------------------------------

    // Halt entered out of wait/stop is remembered until the program resumes
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            halt_from_ws_reg <= 1'b0;
        else if (ce)
        begin
            if (halt_request && wait_stop_sync)
                halt_from_ws_reg <= 1'b1;
            else if (halt_leave)
                halt_from_ws_reg <= 1'b0;
        end
    end

    // Failure set by the memory path; cleared on resume, set wins
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            wait_stop_failure_reg <= 1'b0;
        else if (ce)
        begin
            if (mem_fail_wait_stop)
                wait_stop_failure_reg <= 1'b1;
            else if (halt_leave)
                wait_stop_failure_reg <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Read data and reset pulse
    // ----------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            status_rdata <= `STATUS_CONTROL_RESET;
            bkpt_rdata <= `BKPT_ADDR_RESET;
            mem_rdata <= `FORCE_RESET_READ;
            reset_pulse_reg <= 1'b0;
        end
        else if (ce)
        begin
            if (status_read)
                status_rdata <= status_byte;
            if (breakpoint_fetch_cmd)
                bkpt_rdata <= breakpoint_match_address_reg;
            mem_rdata <= `FORCE_RESET_READ;
            reset_pulse_reg <= force_reset_write;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_permit_gates_halt:
    assert property (@(posedge mclk) disable iff (!rst_n)
        ce && !halt_permit_reg && state_reg == debug_ctrl_pkg::HALT_RUN
        |=> state_reg != debug_ctrl_pkg::HALT_REQ)
    else $error("halt requested without permit");

    a_permit_sticky:
    assert property (@(posedge mclk) disable iff (!rst_n)
        halt_permit_reg |=> halt_permit_reg)
    else $error("halt permit cleared without reset");

    a_permit_locked_halted:
    assert property (@(posedge mclk) disable iff (!rst_n)
        ce && cpu_halted && !halt_permit_reg |=> !halt_permit_reg)
    else $error("halt permit written while halted");

    a_status_fields_live:
    assert property (@(posedge mclk) disable iff (!rst_n)
        ce && status_read |=> status_rdata[`HALT_ACTIVE_BIT] == $past(cpu_halted)
        && status_rdata[`DATA_VALID_FAIL_BIT] == 1'b0)
    else $error("status byte wrong");

    a_bkpt_disabled_quiet:
    assert property (@(posedge mclk) disable iff (!rst_n)
        ce && !breakpoint_enable_reg |=> !force_hit && !tag_hit)
    else $error("breakpoint hit while disabled");

    a_force_to_halt:
    assert property (@(posedge mclk) disable iff (!rst_n)
        ce && force_pending_reg && cpu_inst_boundary && halt_permit_reg
        && state_reg == debug_ctrl_pkg::HALT_RUN && !cpu_halted
        |=> halt_request)
    else $error("forced breakpoint did not request halt");

    a_failure_flag_set:
    assert property (@(posedge mclk) disable iff (!rst_n)
        ce && mem_fail_wait_stop |=> status_byte[`WAIT_STOP_FAIL_BIT])
    else $error("wait/stop failure not flagged");

    a_reset_debug_only:
    assert property (@(posedge mclk) disable iff (!rst_n)
        ce && mem_wr && !mem_from_debug |=> !target_reset)
    else $error("user write forced a reset");

    a_reset_pulse_once:
    assert property (@(posedge mclk) disable iff (!rst_n)
        ce && force_reset_write |=> target_reset ##1 (!target_reset || $past(force_reset_write)))
    else $error("target reset pulse wrong");

    a_force_reg_zero:
    assert property (@(posedge mclk) disable iff (!rst_n)
        mem_rdata == `FORCE_RESET_READ)
    else $error("force reset register read nonzero");

endmodule : debug_ctrl_status_breakpoint

// [sim/debug_host_model.sv]
// Behavioural debug host that issues serial debug commands to the block
`timescale 1ns/1ps
module debug_host_model
(
    input wire logic mclk,
    output logic status_read,
    output logic control_write,
    output logic [7:0] control_wdata,
    output logic breakpoint_store_cmd,
    output logic breakpoint_fetch_cmd,
    output logic [15:0] bkpt_wdata,
    output logic halt_cmd,
    output logic mem_wr,
    output logic mem_rd,
    output logic mem_from_debug,
    output logic [15:0] mem_addr,
    output logic [7:0] mem_wdata
);
    // ----------------------------------------------------------------
    // Idle levels at time zero
    // ----------------------------------------------------------------
    initial
    begin
        {status_read, control_write, breakpoint_store_cmd, breakpoint_fetch_cmd} = 4'h0;
        {halt_cmd, mem_wr, mem_rd, mem_from_debug} = 4'h0;
        control_wdata = 8'h00;
        bkpt_wdata = 16'h0000;
        mem_addr = 16'h0000;
        mem_wdata = 8'h00;
    end

    // ----------------------------------------------------------------
    // Command tasks; released data lines show the inverse, not stale values
    // ----------------------------------------------------------------
    task automatic write_control(input logic [7:0] data);
        @(negedge mclk);
        control_wdata = data;
        control_write = 1'b1;
        @(negedge mclk);
        control_write = 1'b0;
        control_wdata = ~data;
    endtask : write_control

    task automatic read_status();
        @(negedge mclk);
        status_read = 1'b1;
        @(negedge mclk);
        status_read = 1'b0;
    endtask : read_status

    task automatic store_bkpt(input logic [15:0] addr);
        @(negedge mclk);
        bkpt_wdata = addr;
        breakpoint_store_cmd = 1'b1;
        @(negedge mclk);
        breakpoint_store_cmd = 1'b0;
        bkpt_wdata = ~addr;
    endtask : store_bkpt

    task automatic fetch_bkpt();
        @(negedge mclk);
        breakpoint_fetch_cmd = 1'b1;
        @(negedge mclk);
        breakpoint_fetch_cmd = 1'b0;
    endtask : fetch_bkpt

    task automatic halt();
        @(negedge mclk);
        halt_cmd = 1'b1;
        @(negedge mclk);
        halt_cmd = 1'b0;
    endtask : halt

    // One memory cycle; from_debug low stands for a user-program access
    task automatic mem_access(input logic wr, input logic dbg, input logic [15:0] addr,
                              input logic [7:0] data);
        @(negedge mclk);
        mem_wr = wr;
        mem_rd = ~wr;
        mem_from_debug = dbg;
        mem_addr = addr;
        mem_wdata = data;
        @(negedge mclk);
        {mem_wr, mem_rd, mem_from_debug} = 3'h0;
        mem_addr = ~addr;
        mem_wdata = ~data;
    endtask : mem_access
endmodule : debug_host_model

// [sim/debug_ctrl_status_breakpoint_tb.sv]
// Self-checking testbench for the debug status, control and breakpoint block
`timescale 1ns/1ps
module debug_ctrl_status_breakpoint_tb;
    logic mclk, rst_n, ce, reset_in_halt, mem_fail_wait_stop, cpu_wait_stop, cpu_halted;
    logic cpu_addr_valid, cpu_opcode_fetch, cpu_inst_boundary, stat_pend, bkpt_pend;
    logic status_read, control_write, breakpoint_store_cmd, breakpoint_fetch_cmd, halt_cmd;
    logic mem_wr, mem_rd, mem_from_debug, mem_hit, halt_request, wake_request, opcode_tag;
    logic comm_clock_select, target_reset;
    logic [7:0] control_wdata, status_rdata, mem_wdata, mem_rdata, ctrl;
    logic [15:0] bkpt_wdata, bkpt_rdata, mem_addr, cpu_addr, addr;
    logic [7:0] stat_q[$];
    logic [15:0] bkpt_q[$];
    integer seed = 32'h892a;
    int num_errors = 0;
    int checked = 0;

    // ----------------------------------------------------------------
    // Clock, host model and block
    // ----------------------------------------------------------------
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    debug_host_model host (.mclk(mclk), .status_read(status_read),
        .control_write(control_write), .control_wdata(control_wdata),
        .breakpoint_store_cmd(breakpoint_store_cmd), .breakpoint_fetch_cmd(breakpoint_fetch_cmd),
        .bkpt_wdata(bkpt_wdata), .halt_cmd(halt_cmd), .mem_wr(mem_wr), .mem_rd(mem_rd),
        .mem_from_debug(mem_from_debug), .mem_addr(mem_addr), .mem_wdata(mem_wdata));

    debug_ctrl_status_breakpoint dut (.mclk(mclk), .rst_n(rst_n), .ce(ce),
        .reset_in_halt(reset_in_halt), .status_read(status_read),
        .control_write(control_write), .control_wdata(control_wdata),
        .status_rdata(status_rdata), .breakpoint_store_cmd(breakpoint_store_cmd),
        .breakpoint_fetch_cmd(breakpoint_fetch_cmd), .bkpt_wdata(bkpt_wdata),
        .bkpt_rdata(bkpt_rdata), .halt_cmd(halt_cmd), .mem_wr(mem_wr), .mem_rd(mem_rd),
        .mem_from_debug(mem_from_debug), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .mem_hit(mem_hit), .mem_fail_wait_stop(mem_fail_wait_stop),
        .cpu_wait_stop(cpu_wait_stop), .cpu_halted(cpu_halted), .cpu_addr(cpu_addr),
        .cpu_addr_valid(cpu_addr_valid), .cpu_opcode_fetch(cpu_opcode_fetch),
        .cpu_inst_boundary(cpu_inst_boundary), .halt_request(halt_request),
        .wake_request(wake_request), .opcode_tag(opcode_tag),
        .comm_clock_select(comm_clock_select), .target_reset(target_reset));

    // ----------------------------------------------------------------
    // Comparison, verdict and watchdog
    // ----------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
            num_errors++;
        end
    endtask : check

    task automatic results();
        $display("Comparisons %0d, mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : results

    initial
    begin
        repeat (5000) @(posedge mclk);
        num_errors++;
        results();
    end

    // ----------------------------------------------------------------
    // Monitor: read data appears one cycle after the request
    // ----------------------------------------------------------------
    always @(posedge mclk)
    begin
        stat_pend <= status_read && ce;
        bkpt_pend <= breakpoint_fetch_cmd && ce;
    end

    always @(negedge mclk)
    begin
        if (stat_pend && stat_q.size() > 0)
            check({8'h00, status_rdata}, {8'h00, stat_q.pop_front()});
        if (bkpt_pend && bkpt_q.size() > 0)
            check(bkpt_rdata, bkpt_q.pop_front());
    end

    // Force-reset register select stands while a memory strobe is up
    always @(posedge mclk)
    begin
        if (mem_wr || mem_rd)
            check(mem_hit, mem_addr == 16'h1800);
    end

    // ----------------------------------------------------------------
    // Stimulus helpers
    // ----------------------------------------------------------------
    task automatic read_status(input logic [7:0] exp);
        stat_q.push_back(exp);
        host.read_status();
    endtask : read_status

    task automatic do_reset(input logic rih, input int n);
        @(negedge mclk);
        rst_n = 1'b0;
        reset_in_halt = rih;
        repeat (n) @(negedge mclk);
        rst_n = 1'b1;
    endtask : do_reset

    // One CPU bus cycle at a, then an instruction boundary two cycles later
    task automatic cpu_cycle(input logic [15:0] a, input logic exp_tag, input logic exp_halt);
        @(negedge mclk);
        {cpu_addr, cpu_addr_valid, cpu_opcode_fetch} = {a, 2'b11};
        @(negedge mclk);
        {cpu_addr, cpu_addr_valid, cpu_opcode_fetch} = {~a, 2'b00};
        check(opcode_tag, exp_tag);
        repeat (2) @(negedge mclk);
        check(halt_request, 1'b0);
        cpu_inst_boundary = 1'b1;
        @(negedge mclk);
        cpu_inst_boundary = 1'b0;
        check(halt_request, exp_halt);
    endtask : cpu_cycle

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        {rst_n, ce, reset_in_halt, mem_fail_wait_stop, cpu_wait_stop, cpu_halted} = 6'b010000;
        {cpu_addr, cpu_addr_valid, cpu_opcode_fetch, cpu_inst_boundary} = 19'h0;
        do_reset(1'b0, 20);
        read_status(8'h00);
        check(comm_clock_select, 1'b0);
        bkpt_q.push_back(16'h0000);
        host.fetch_bkpt();
        host.halt();
        check(halt_request, 1'b0);
        host.write_control(8'hFF);
        read_status(8'hB8);
        check(comm_clock_select, 1'b1);
        host.write_control(8'h00);
        read_status(8'h80);
        addr = $random(seed);
        host.store_bkpt(addr);
        bkpt_q.push_back(addr);
        host.fetch_bkpt();
        // Disabled, disabled-forced, tagged and forced breakpoint kinds
        for (int i = 0; i < 4; i++)
        begin
            ctrl = 8'h80 | (8'h10 * i[7:0]);
            host.write_control(ctrl);
            cpu_cycle(addr, ctrl == 8'hA0, ctrl == 8'hB0);
        end
        cpu_halted = 1'b1;
        repeat (2) @(negedge mclk);
        check(halt_request, 1'b0);
        read_status(8'hF0);
        cpu_halted = 1'b0;
        host.write_control(8'h80);
        // Halt out of wait/stop, then a failed memory command
        cpu_wait_stop = 1'b1;
        repeat (8) @(negedge mclk);
        read_status(8'h84);
        host.halt();
        check(halt_request, 1'b1);
        check(wake_request, 1'b1);
        cpu_halted = 1'b1;
        cpu_wait_stop = 1'b0;
        repeat (8) @(negedge mclk);
        read_status(8'hC4);
        mem_fail_wait_stop = 1'b1;
        @(negedge mclk);
        mem_fail_wait_stop = 1'b0;
        read_status(8'hC6);
        host.mem_access(1'b0, 1'b1, addr, 8'h00);
        cpu_halted = 1'b0;
        repeat (2) @(negedge mclk);
        read_status(8'h80);
        // Force-reset register
        host.mem_access(1'b1, 1'b0, 16'h1800, 8'h01);
        check(target_reset, 1'b0);
        host.mem_access(1'b1, 1'b1, 16'h1800, 8'hFE);
        check(target_reset, 1'b0);
        host.mem_access(1'b1, 1'b1, 16'h1800, 8'h01 | 8'($random(seed)));
        check(target_reset, 1'b1);
        @(negedge mclk);
        check(target_reset, 1'b0);
        host.mem_access(1'b0, 1'b1, 16'h1800, 8'h00);
        check(mem_rdata, 8'h00);
        // Reset values and permit writes while halted
        cpu_halted = 1'b1;
        do_reset(1'b1, 3);
        read_status(8'hC8);
        do_reset(1'b0, 3);
        read_status(8'h40);
        host.write_control(8'h80);
        read_status(8'h40);
        // Frozen while the clock enable is low; clock select still writable when halted
        ce = 1'b0;
        host.write_control(8'h08);
        ce = 1'b1;
        read_status(8'h40);
        host.write_control(8'h88);
        read_status(8'h48);
        repeat (2) @(negedge mclk);
        results();
    end
endmodule : debug_ctrl_status_breakpoint_tb
